// ===== hdl/fcps_pkg.sv
// Shared constants and types for the four-channel power sequencer
package fcps_pkg;
   localparam int NCH = 4;
   localparam int CLK_MHZ = 100;
   // Timebase tick, in microseconds, and its length in clock cycles
   localparam int TICK_US = 100;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   // Glitch filter window
   localparam int GLITCH_US = 8;
   localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
   // Monitor reference code ceiling: 1.0 V in 4 mV steps
   localparam int REF_MV_MAX = 1000;
   localparam int REF_MV_STEP = 4;
   localparam logic [7:0] REF_CODE_MAX = 8'(REF_MV_MAX / REF_MV_STEP);
   // Power-off step delays in microseconds, by select code
   localparam int OFF_DLY_US0 = 1500;
   localparam int OFF_DLY_US1 = 12500;
   localparam int OFF_DLY_US2 = 25000;
   localparam int OFF_DLY_US3 = 50000;
   // Sequence abort periods in milliseconds, by select code
   localparam int ABORT_MS0 = 50;
   localparam int ABORT_MS1 = 100;
   localparam int ABORT_MS2 = 200;
   localparam int TICKS_PER_MS = 1000 / TICK_US;
   // Threshold percentage steps
   localparam int THR_PCT_STEP = 5;
   // Soft-start slew references in volts per second, by select code
   localparam logic [8:0] SLEW_V0 = 9'h190;
   localparam logic [8:0] SLEW_V1 = 9'h0C8;
   localparam logic [8:0] SLEW_V2 = 9'h064;
   localparam logic [8:0] SLEW_V3 = 9'h043;
   localparam logic [8:0] SLEW_V4 = 9'h032;
   localparam logic [8:0] SLEW_V5 = 9'h021;
   localparam logic [8:0] SLEW_V6 = 9'h019;
   localparam logic [8:0] SLEW_V7 = 9'h014;
   // Margin select codes and the last sequence position
   localparam logic [1:0] MARGIN_NOM = 2'h0;
   localparam logic [1:0] MARGIN_HIGH = 2'h1;
   localparam logic [1:0] MARGIN_LOW = 2'h2;
   localparam logic [1:0] LAST_POS = 2'h3;
   // Response to a fault or a battery level
   typedef enum logic [1:0]
   {
      ACT_NONE = 2'b00,
      ACT_FORCE = 2'b01,
      ACT_SEQ = 2'b10
   } fcps_action_e;
   // Sequencer states
   typedef enum logic [2:0]
   {
      ST_OFF = 3'b000,
      ST_ON_SEQ = 3'b001,
      ST_RUN = 3'b010,
      ST_OFF_WAIT = 3'b011,
      ST_OFF_DLY = 3'b100
   } fcps_state_e;
endpackage

// ===== hdl/fcps_glitch_filter.sv
// Per-output UV/OV glitch filter
module fcps_glitch_filter
   import fcps_pkg::*;
#(
   parameter int CYC = GLITCH_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mon_en,
   input wire logic long_en,
   input wire logic raw,
   output logic fault
);
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic flt_reg;
   logic flt_next;

   // Violation must outlast the window before it counts
   always_comb
   begin
      cnt_next = cnt_reg;
      flt_next = 1'b0;
      if (!mon_en || !raw)
      begin
         cnt_next = '0;
      end
      else if (!long_en)
      begin
         flt_next = 1'b1;
      end
      else if (cnt_reg == 12'(CYC))
      begin
         flt_next = 1'b1;
      end
      else
      begin
         cnt_next = cnt_reg + 12'h001;
      end
   end

   // Filter state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         flt_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         flt_reg <= flt_next;
      end
   end

   assign fault = flt_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Filtered fault needs a violation longer than the window
   a_filter_window: assert property (long_en && !$past(fault) && fault |->
      $past(raw, 2) && $past(mon_en, 2))
      else $error("fault without sustained violation");
   cv_filter_trip: cover property (long_en ##1 fault);
endmodule

// ===== hdl/fcps_core.sv
// Four-channel power sequencer control core
module fcps_core
   import fcps_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int FILTER_CYCLES = GLITCH_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic supply_ok,
   input wire logic cmd_power_on,
   input wire logic cmd_power_off,
   input wire logic cmd_force_off,
   input wire logic power_enable_pin_b,
   input wire logic [3:0] chan_enable,
   input wire logic [3:0] chan_manual,
   input wire logic [7:0] chan_position,
   input wire logic [3:0] chan_up,
   input wire logic [3:0] chan_off,
   input wire logic abort_en,
   input wire logic [1:0] abort_sel,
   input wire logic [1:0] off_delay_sel,
   input wire logic [3:0] uv_raw,
   input wire logic [3:0] ov_raw,
   input wire logic filter_long,
   input wire logic [1:0] fault_action,
   input wire logic fault_healthy_en,
   input wire logic [7:0] uv_thr_sel,
   input wire logic [7:0] ov_thr_sel,
   input wire logic [31:0] ref_code,
   input wire logic below_level_one,
   input wire logic below_level_two,
   input wire logic [1:0] level_one_action,
   input wire logic [1:0] level_two_action,
   input wire logic battery_latch_off,
   input wire logic [2:0] slew_sel,
   input wire logic [3:0] slew_off,
   input wire logic margin_cmd_valid,
   input wire logic [7:0] margin_cmd,
   input wire logic seven_level_en,
   input wire logic seven_level_wr,
   input wire logic [2:0] seven_level_val,
   input wire logic [3:0] chan_at_target,
   output logic [3:0] chan_on,
   output logic [3:0] chan_slew_en,
   output logic [1:0] seq_position,
   output logic healthy_fault,
   output logic battery_fault_flag,
   output logic battery_low_flag,
   output logic [8:0] slew_ref_vps,
   output logic [19:0] thr_pct,
   output logic [31:0] mon_ref_code,
   output logic [7:0] margin_sel,
   output logic [2:0] seven_level_idx,
   output logic margin_done
);
   localparam logic [15:0] OFF_T0 = 16'(OFF_DLY_US0 / TICK_US);
   localparam logic [15:0] OFF_T1 = 16'(OFF_DLY_US1 / TICK_US);
   localparam logic [15:0] OFF_T2 = 16'(OFF_DLY_US2 / TICK_US);
   localparam logic [15:0] OFF_T3 = 16'(OFF_DLY_US3 / TICK_US);
   localparam logic [15:0] ABT_T0 = 16'(ABORT_MS0 * TICKS_PER_MS);
   localparam logic [15:0] ABT_T1 = 16'(ABORT_MS1 * TICKS_PER_MS);
   localparam logic [15:0] ABT_T2 = 16'(ABORT_MS2 * TICKS_PER_MS);

   logic rs1_reg;
   logic rs2_reg;
   logic srst_n;
   logic [15:0] tick_cnt_reg;
   logic tick;
   fcps_state_e state_reg;
   fcps_state_e state_next;
   logic [1:0] pos_reg;
   logic [1:0] pos_next;
   logic [3:0] mask_reg;
   logic [3:0] mask_next;
   logic [15:0] tmr_reg;
   logic [15:0] tmr_next;
   logic [15:0] abt_reg;
   logic [15:0] abt_next;
   logic boff_reg;
   logic boff_next;
   logic hflt_reg;
   logic hflt_next;
   logic pinb_reg;
   logic [3:0] on_reg;
   logic [3:0] on_next;
   logic [3:0] flt;
   logic [3:0] pos_ch;
   logic [15:0] off_ticks;
   logic [15:0] abt_ticks;
   logic flt_any;
   logic abort_exp;
   logic batt_force;
   logic batt_seq;
   logic force_off;
   logic off_req;
   logic active;

   ////////////////////////////////////////////////////////////////////////
   // Reset release and timebase

   // Two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   assign srst_n = rs2_reg;

   // Tick divider, held clear under lockout
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         tick_cnt_reg <= '0;
         pinb_reg <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= (!supply_ok || tick) ? '0 : tick_cnt_reg + 16'h0001;
         pinb_reg <= power_enable_pin_b;
      end
   end
   assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////
   // Output monitors

   // One glitch filter per output, UV and OV merged
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_mon
         fcps_glitch_filter #(.CYC(FILTER_CYCLES)) u_flt
         (
            .clk(clk),
            .rst_n(srst_n),
            .mon_en(on_reg[gi] && supply_ok),
            .long_en(filter_long),
            .raw(uv_raw[gi] || ov_raw[gi]),
            .fault(flt[gi])
         );
         assign pos_ch[gi] = (chan_position[2*gi+:2] == pos_reg) && !chan_manual[gi];
      end
   endgenerate

   // Delay selection in ticks
   always_comb
   begin
      unique case (off_delay_sel)
         2'h0: off_ticks = OFF_T0;
         2'h1: off_ticks = OFF_T1;
         2'h2: off_ticks = OFF_T2;
         default: off_ticks = OFF_T3;
      endcase
      unique case (abort_sel)
         2'h0: abt_ticks = ABT_T0;
         2'h1: abt_ticks = ABT_T1;
         default: abt_ticks = ABT_T2;
      endcase
   end

   // Shutdown causes
   assign active = (state_reg == ST_ON_SEQ) || (state_reg == ST_RUN);
   assign flt_any = |flt;
   assign abort_exp = abort_en && (state_reg == ST_ON_SEQ) && (abt_reg == abt_ticks);
   assign batt_force = (below_level_one && level_one_action == ACT_FORCE) ||
      (below_level_two && level_two_action == ACT_FORCE);
   assign batt_seq = (below_level_one && level_one_action == ACT_SEQ) ||
      (below_level_two && level_two_action == ACT_SEQ);
   assign force_off = cmd_force_off || abort_exp || batt_force ||
      (flt_any && fault_action == ACT_FORCE);
   assign off_req = cmd_power_off || (power_enable_pin_b && !pinb_reg) || batt_seq ||
      (flt_any && fault_action == ACT_SEQ);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Next-state logic for positions, timers and channel mask
   always_comb
   begin
      state_next = state_reg;
      pos_next = pos_reg;
      mask_next = mask_reg;
      tmr_next = tmr_reg;
      abt_next = (tick && state_reg == ST_ON_SEQ) ? abt_reg + 16'h0001 : abt_reg;
      boff_next = boff_reg;
      hflt_next = cmd_power_on ? 1'b0 : hflt_reg;
      if (flt_any && fault_healthy_en)
      begin
         hflt_next = 1'b1;
      end
      if (!supply_ok)
      begin
         state_next = ST_OFF;
         pos_next = '0;
         mask_next = '0;
         tmr_next = '0;
         abt_next = '0;
      end
      else if (state_reg != ST_OFF && force_off)
      begin
         state_next = ST_OFF;
         mask_next = '0;
         boff_next = boff_reg || batt_force;
      end
      else
      begin
         unique case (state_reg)
            ST_OFF:
            begin
               if (cmd_power_on || (power_enable_pin_b && !pinb_reg) ||
                  (boff_reg && !battery_latch_off && !below_level_one && !below_level_two))
               begin
                  state_next = ST_ON_SEQ;
                  pos_next = '0;
                  abt_next = '0;
                  boff_next = 1'b0;
               end
            end
            ST_ON_SEQ, ST_RUN:
            begin
               if (off_req)
               begin
                  state_next = ST_OFF_WAIT;
                  pos_next = LAST_POS;
                  boff_next = boff_reg || batt_seq;
               end
               else if (state_reg == ST_RUN)
               begin
                  mask_next = mask_reg & chan_enable;
               end
               else
               begin
                  mask_next = mask_reg | (pos_ch & chan_enable);
                  if ((pos_ch & ~(mask_reg & chan_up)) == 4'h0)
                  begin
                     abt_next = '0;
                     if (pos_reg == LAST_POS)
                     begin
                        state_next = ST_RUN;
                     end
                     else
                     begin
                        pos_next = pos_reg + 2'h1;
                     end
                  end
               end
            end
            ST_OFF_WAIT:
            begin
               mask_next = mask_reg & ~pos_ch;
               if ((pos_ch & ~chan_off) == 4'h0)
               begin
                  tmr_next = '0;
                  state_next = (pos_reg == 2'h0) ? ST_OFF : ST_OFF_DLY;
               end
            end
            ST_OFF_DLY:
            begin
               if (tmr_reg == off_ticks)
               begin
                  state_next = ST_OFF_WAIT;
                  pos_next = pos_reg - 2'h1;
               end
               else if (tick)
               begin
                  tmr_next = tmr_reg + 16'h0001;
               end
            end
         endcase
      end
      // Manual channels follow their enable alone
      on_next = (chan_manual & chan_enable) | (~chan_manual & mask_next);
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         state_reg <= ST_OFF;
         pos_reg <= '0;
         mask_reg <= '0;
         tmr_reg <= '0;
         abt_reg <= '0;
         boff_reg <= 1'b0;
         hflt_reg <= 1'b0;
         on_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         pos_reg <= pos_next;
         mask_reg <= mask_next;
         tmr_reg <= tmr_next;
         abt_reg <= abt_next;
         boff_reg <= boff_next;
         hflt_reg <= hflt_next;
         on_reg <= on_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog settings, battery flags and margining

   logic [3:0] slew_en_next;
   logic [8:0] slew_next;
   logic [19:0] pct_next;
   logic [31:0] ref_next;
   logic [1:0] bflag_next;
   logic [7:0] msel_next;
   logic [2:0] sidx_next;
   logic mbusy_next;
   logic mdone_next;
   logic [3:0] slew_en_reg;
   logic [8:0] slew_reg;
   logic [19:0] pct_reg;
   logic [31:0] ref_reg;
   logic [1:0] bflag_reg;
   logic [7:0] msel_reg;
   logic [2:0] sidx_reg;
   logic mbusy_reg;
   logic mdone_reg;

   // Settings and margin next values
   always_comb
   begin
      slew_en_next = ~slew_off;
      if (state_reg == ST_OFF_WAIT || state_reg == ST_OFF_DLY)
      begin
         slew_en_next = 4'h0;
      end
      unique case (slew_sel)
         3'h0: slew_next = SLEW_V0;
         3'h1: slew_next = SLEW_V1;
         3'h2: slew_next = SLEW_V2;
         3'h3: slew_next = SLEW_V3;
         3'h4: slew_next = SLEW_V4;
         3'h5: slew_next = SLEW_V5;
         3'h6: slew_next = SLEW_V6;
         3'h7: slew_next = SLEW_V7;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
         pct_next[5*c+:5] = 5'(THR_PCT_STEP * (int'(uv_thr_sel[2*c+:2]) + 1));
         ref_next[8*c+:8] = (ref_code[8*c+:8] > REF_CODE_MAX) ?
            REF_CODE_MAX : ref_code[8*c+:8];
      end
      bflag_next = {below_level_two, below_level_one};
      msel_next = msel_reg;
      sidx_next = sidx_reg;
      mbusy_next = mbusy_reg;
      mdone_next = mdone_reg;
      if (mbusy_reg && (&chan_at_target))
      begin
         mbusy_next = 1'b0;
         mdone_next = 1'b1;
      end
      if (margin_cmd_valid)
      begin
         msel_next = margin_cmd;
         mbusy_next = 1'b1;
         mdone_next = 1'b0;
      end
      if (seven_level_en && seven_level_wr)
      begin
         sidx_next = seven_level_val;
         mbusy_next = 1'b1;
         mdone_next = 1'b0;
      end
      if (seven_level_en)
      begin
         msel_next[3:2] = MARGIN_NOM;
      end
   end

   // Settings and margin registers
   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         slew_en_reg <= '0;
         slew_reg <= '0;
         pct_reg <= '0;
         ref_reg <= '0;
         bflag_reg <= '0;
         msel_reg <= '0;
         sidx_reg <= '0;
         mbusy_reg <= 1'b0;
         mdone_reg <= 1'b0;
      end
      else
      begin
         slew_en_reg <= slew_en_next;
         slew_reg <= slew_next;
         pct_reg <= pct_next;
         ref_reg <= ref_next;
         bflag_reg <= bflag_next;
         msel_reg <= msel_next;
         sidx_reg <= sidx_next;
         mbusy_reg <= mbusy_next;
         mdone_reg <= mdone_next;
      end
   end

   assign chan_on = on_reg;
   assign chan_slew_en = slew_en_reg;
   assign seq_position = pos_reg;
   assign healthy_fault = hflt_reg;
   assign battery_fault_flag = bflag_reg[0];
   assign battery_low_flag = bflag_reg[1];
   assign slew_ref_vps = slew_reg;
   assign thr_pct = pct_reg;
   assign mon_ref_code = ref_reg;
   assign margin_sel = msel_reg;
   assign seven_level_idx = sidx_reg;
   assign margin_done = mdone_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking @(posedge clk); endclocking
   default disable iff (!srst_n);

   a_manual_follow: assert property (##1 on_reg == ((on_reg & ~$past(chan_manual)) |
      ($past(chan_manual) & $past(chan_enable))))
      else $error("manual channel not following its enable");
   a_manual_hold: assert property (chan_manual[0] && chan_enable[0] &&
      $past(chan_manual[0]) && $past(chan_enable[0]) |-> on_reg[0])
      else $error("manual channel dropped");
   a_force_all: assert property (supply_ok && cmd_force_off && state_reg != ST_OFF |=>
      state_reg == ST_OFF && mask_reg == 4'h0)
      else $error("force shutdown left channels on");
   a_abort_force: assert property (abort_exp && supply_ok |=> state_reg == ST_OFF)
      else $error("abort expiry did not shut down");
   a_off_jump: assert property (active && supply_ok && !force_off && off_req |=>
      state_reg == ST_OFF_WAIT && pos_reg == LAST_POS)
      else $error("power-off did not start at last position");
   a_off_reverse: assert property (state_reg == ST_OFF_DLY && state_next == ST_OFF_WAIT
      |=> pos_reg == $past(pos_reg) - 2'h1)
      else $error("power-off not stepping backwards");
   a_off_noslew: assert property (state_reg == ST_OFF_WAIT |=> slew_en_reg == 4'h0)
      else $error("soft-start active during power-off");
   a_ref_clamp: assert property (mon_ref_code[7:0] <= REF_CODE_MAX)
      else $error("reference code above full scale");
   a_margin_done: assert property (mbusy_reg && (&chan_at_target) && !margin_cmd_valid
      && !seven_level_wr |=> margin_done)
      else $error("margin status not set");
   a_seven_ch1: assert property (seven_level_en |=> margin_sel[3:2] == MARGIN_NOM)
      else $error("channel 1 margin kept in seven-level mode");
   a_lockout_clear: assert property (!supply_ok |=>
      state_reg == ST_OFF && tmr_reg == 16'h0)
      else $error("lockout did not clear sequencer");

   cv_run: cover property (state_reg == ST_ON_SEQ ##[1:1000] state_reg == ST_RUN);
   cv_off_seq: cover property (state_reg == ST_OFF_DLY ##1 state_reg == ST_OFF_WAIT);
   cv_margin: cover property (margin_cmd_valid ##[1:50] margin_done);
   cv_batt_restart: cover property (boff_reg && state_reg == ST_OFF ##1 state_reg == ST_ON_SEQ);
endmodule

// ===== test/fcps_plant.sv
// Plant model: output rails answering the sequencer's enables
module fcps_plant
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] chan_on,
   input wire logic slow,
   output logic [3:0] chan_up,
   output logic [3:0] chan_off,
   output logic [3:0] chan_at_target
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] d1_reg, d2_reg;
   // Two-cycle rail rise and discharge lag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         {d1_reg, d2_reg} <= 8'h00;
      else
         {d1_reg, d2_reg} <= {chan_on, d1_reg};
   end
   // Slow rails never pass the threshold
   assign chan_up = slow ? 4'h0 : chan_on & d2_reg;
   assign chan_at_target = chan_up;
   assign chan_off = ~(chan_on | d2_reg);
endmodule

// ===== test/tb_fcps_core.sv
// Self-checking bench for the sequencer core
module tb_fcps_core;
   import fcps_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rst_n = 1'h0, supply_ok = 1'h1, slow = 1'h0, abort_en = 1'h0;
   logic cmd_power_on = 1'h0, cmd_power_off = 1'h0, cmd_force_off = 1'h0, filter_long = 1'h1;
   logic fault_healthy_en = 1'h0, below_level_one = 1'h0, below_level_two = 1'h0;
   logic margin_cmd_valid = 1'h0, seven_level_en = 1'h0, seven_level_wr = 1'h0;
   logic power_enable_pin_b = 1'h0, battery_latch_off = 1'h0, margin_done;
   logic healthy_fault, battery_fault_flag, battery_low_flag;
   logic [1:0] abort_sel = 2'h0, off_delay_sel = 2'h0, fault_action = 2'h0, seq_position;
   logic [1:0] level_one_action = 2'h0, level_two_action = 2'h1;
   logic [2:0] slew_sel = 3'h0, seven_level_val = 3'h0, seven_level_idx;
   logic [3:0] chan_enable = 4'hF, chan_manual = 4'h0, slew_off = 4'h0, uv_raw = 4'h0;
   logic [3:0] ov_raw = 4'h0, chan_up, chan_off, chan_at_target, chan_on, chan_slew_en;
   logic [7:0] chan_position = 8'hE4, uv_thr_sel = 8'h0, ov_thr_sel = 8'h0;
   logic [7:0] margin_cmd = 8'h0, margin_sel;
   logic [8:0] slew_ref_vps;
   logic [19:0] thr_pct;
   logic [31:0] ref_code = 32'h0, mon_ref_code;
   int n_mismatch = 0, compares = 0, cyc = 0, w = 0;
   int vps[8] = '{400, 200, 100, 67, 50, 33, 25, 20};
   // Clock, core and plant
   always #5 clk = ~clk;
   fcps_core #(.TICK_CYCLES(10), .FILTER_CYCLES(8)) i_dut (.*);
   fcps_plant i_plant (.*);
   // Cycle ceiling against a hang
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      n_mismatch += int'(cyc == 40000);
      if (cyc == 40000)
         wrap_up;
   end
   task wrap_up;
      $display("mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      n_mismatch += int'(got !== exp);
      if (got !== exp)
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
   endtask
   task at(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait on the rail enables, cycles counted in w
   task wt(input logic [3:0] e);
      w = 0;
      while (chan_on !== e && w < 8000)
      begin
         @(negedge clk);
         w++;
      end
      chk(chan_on, e);
   endtask
   task pon;
      @(posedge clk) cmd_power_on <= 1'h1;
      @(posedge clk) cmd_power_on <= 1'h0;
      wt(4'hF);
   endtask
   // Output decodes and margin handling
   task t_decode;
      @(posedge clk) uv_thr_sel <= 8'h1B;
      ref_code <= 32'h00FAFBFF;
      slew_off <= 4'h5;
      margin_cmd <= 8'h24;
      margin_cmd_valid <= 1'h1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk) slew_sel <= i[2:0];
         margin_cmd_valid <= 1'h0;
         at(3);
         chk(slew_ref_vps, vps[i]);
      end
      chk(thr_pct, {5'h05, 5'h0A, 5'h0F, 5'h14});
      chk(mon_ref_code, 32'h00FAFAFA);
      chk(chan_slew_en, 4'hA);
      chk(margin_sel, 8'h24);
      chk(margin_done, 1'h1);
      @(posedge clk) seven_level_en <= 1'h1;
      seven_level_wr <= 1'h1;
      seven_level_val <= 3'h5;
      margin_cmd_valid <= 1'h1;
      @(posedge clk) seven_level_wr <= 1'h0;
      margin_cmd_valid <= 1'h0;
      at(3);
      chk(margin_sel, 8'h20);
      chk(seven_level_idx, 3'h5);
   endtask
   // Short glitch ignored, long one forces off
   task t_fault;
      @(posedge clk) fault_action <= 2'h1;
      fault_healthy_en <= 1'h1;
      uv_raw <= 4'h2;
      repeat (5) @(posedge clk);
      uv_raw <= 4'h0;
      at(20);
      chk(chan_on, 4'hF);
      @(posedge clk) ov_raw <= 4'h8;
      wt(4'h0);
      chk(w >= 8, 1'h1);
      chk(healthy_fault, 1'h1);
      @(posedge clk) ov_raw <= 4'h0;
   endtask
   // Reverse-order power-off with enables dropped
   task t_off(input bit pin);
      pon;
      @(posedge clk) off_delay_sel <= {1'h0, pin};
      power_enable_pin_b <= pin;
      cmd_power_off <= !pin;
      @(posedge clk) cmd_power_off <= 1'h0;
      chan_enable <= 4'h0;
      wt(4'h7);
      chk(chan_slew_en, 4'h0);
      wt(4'h3);
      chk(w >= (pin ? 1240 : 140), 1'h1);
      wt(4'h1);
      wt(4'h0);
      // Let the last rail discharge so the sequencer is back in its off state
      at(4);
      @(posedge clk) power_enable_pin_b <= 1'h0;
      chan_enable <= 4'hF;
   endtask
   // Battery levels: flag only, forced off, auto restart
   task t_batt;
      @(posedge clk) level_two_action <= 2'h0;
      level_one_action <= 2'h1;
      below_level_two <= 1'h1;
      at(3);
      chk(battery_low_flag, 1'h1);
      chk(chan_on, 4'hF);
      @(posedge clk) below_level_one <= 1'h1;
      wt(4'h0);
      chk(battery_fault_flag, 1'h1);
      @(posedge clk) below_level_one <= 1'h0;
      below_level_two <= 1'h0;
      wt(4'hF);
      // Sequenced power-off on level two, then latched off until a command
      @(posedge clk) battery_latch_off <= 1'h1;
      level_two_action <= 2'h2;
      below_level_two <= 1'h1;
      wt(4'h7);
      wt(4'h0);
      @(posedge clk) below_level_two <= 1'h0;
      at(20);
      chk(chan_on, 4'h0);
      pon;
      @(posedge clk) battery_latch_off <= 1'h0;
   endtask
   // Force-off, then a manual channel under lockout
   task t_manual;
      @(posedge clk) cmd_force_off <= 1'h1;
      @(posedge clk) cmd_force_off <= 1'h0;
      at(2);
      chk(chan_on, 4'h0);
      @(posedge clk) chan_manual <= 4'h1;
      at(3);
      chk(chan_on, 4'h1);
      @(posedge clk) supply_ok <= 1'h0;
      at(3);
      chk(chan_on, 4'h1);
      @(posedge clk) chan_enable <= 4'hE;
      at(3);
      chk(chan_on, 4'h0);
      @(posedge clk) supply_ok <= 1'h1;
      chan_manual <= 4'h0;
      chan_enable <= 4'hF;
   endtask
   // Stuck cascade ends in a forced shutdown
   task t_abort;
      @(posedge clk) slow <= 1'h1;
      abort_en <= 1'h1;
      cmd_power_on <= 1'h1;
      @(posedge clk) cmd_power_on <= 1'h0;
      at(4800);
      chk(chan_on, 4'h1);
      wt(4'h0);
      chk(w < 400, 1'h1);
   endtask
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      pon;
      chk(seq_position, LAST_POS);
      t_decode;
      t_fault;
      t_off(1'b0);
      t_off(1'b1);
      pon;
      t_batt;
      t_manual;
      t_abort;
      wrap_up;
   end
endmodule
